// ---- rtl/tsp_packer.sv ----
/*
 * Transport packer: gathers converter samples and emits per-lane frames
 * for link modes 0 to 3, one octet per lane per cycle.
 * Assumes samples and mode straps come from logic on the same clock and
 * that mode and channel count only change while reset is held.
 */
`timescale 1ns/1ps
// Overview of operation
// - Mode 0: eight-octet lanes, five 9-bit-plus-000 fields, 4-bit tail; even/odd samples split.
// - Mode 1: two-octet lanes, 12-bit widened samples packed contiguously across three lanes.
// - Mode 1 single channel: lane one octet one is zero; third lane dual/quad only.
// - Mode 2: one octet per lane, 8-bit sample, lanes zero..three carry A..D.
// - Mode 3: five-octet lanes, four 10-bit fields of sample plus zero.
// - Channel B lane only for dual/quad; C and D lanes only for quad.
// - All tail positions in a frame are zero.
// - Samples are placed most significant bit first.
// - Lowest lanes are used, higher lanes powered down; receiver uses lowest lanes.
module tsp_packer
    import tsp_pkg::*;
(
    input wire logic ref_clk_i,                // Packer clock, 100 MHz.
    input wire logic rst_n_i,                  // Synchronous reset, active low.
    input wire logic [1:0] link_mode_select_i, // Link mode, taken during reset.
    input wire logic [1:0] chan_cfg_i,         // Single, dual or quad, taken during reset.
    input wire logic [35:0] sample_data_i,     // Channels D..A, 9 bits each, A lowest.
    input wire logic sample_valid_i,           // Sample word valid.
    output logic sample_ready_o,               // Sample word accepted when high.
    output logic [63:0] lane_octet_o,          // Octet per lane, lane_zero in bits 7:0.
    output logic octet_valid_o,                // Lane octets valid this cycle.
    output logic frame_start_o,                // Octet 0 of a frame this cycle.
    output logic [7:0] lane_en_o               // Lanes powered up.
);

    typedef struct packed {
        tsp_state_t st;
        logic [3:0] cnt;
        logic [3:0] oct;
        tsp_mode_t mode;
        tsp_cfg_t cfg;
        logic [TSP_CH-1:0][TSP_MAXS-1:0][TSP_SW-1:0] smp;
        logic [TSP_LANES-1:0][TSP_FRM_W-1:0] frm;
        logic [63:0] lane_oct;
        logic valid;
        logic start;
        logic [7:0] en;
    } tsp_top_st_t;

    tsp_top_st_t q;
    tsp_top_st_t d;

    tsp_stream_if #(.W(TSP_FIFO_W)) in_if ();
    tsp_stream_if #(.W(TSP_FIFO_W)) out_if ();

    // The FIFO absorbs samples while a frame is being sent, and its
    // ready stalls the converter once it is full.
    assign in_if.valid = sample_valid_i;
    assign in_if.data = sample_data_i;
    assign sample_ready_o = in_if.ready;
    assign out_if.ready = (q.st == TSP_COLLECT);

    tsp_fifo #(.W(TSP_FIFO_W), .DEPTH(TSP_FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_if(in_if),
        .out_if(out_if)
    );

    // Builds one frame per lane, left justified, from the gathered samples.
    function automatic logic [TSP_LANES-1:0][TSP_FRM_W-1:0] tsp_build(
        input tsp_mode_t m,
        input tsp_cfg_t c,
        input logic [TSP_CH-1:0][TSP_MAXS-1:0][TSP_SW-1:0] s
    );
        logic [TSP_LANES-1:0][TSP_FRM_W-1:0] f;
        logic [TSP_CH-1:0][TSP_MAXS-1:0][TSP_SW-1:0] z;
        logic [47:0] p;
        f = '0;
        z = s;
        p = '0;
        // Absent channels are zeroed, so their lanes and shared octets stay zero.
        for (int ch = 1; ch < TSP_CH; ch++) begin
            if ((c == TSP_SINGLE) || (c == TSP_DUAL && ch > 1)) begin
                z[ch] = '0;
            end
        end
        case (m)
            TSP_MODE0: begin
                for (int ch = 0; ch < TSP_CH; ch++) begin
                    for (int k = 0; k < 5; k++) begin
                        f[2*ch][63-12*k -: 12] = {z[ch][2*k], 3'h0};
                        f[2*ch+1][63-12*k -: 12] = {z[ch][2*k+1], 3'h0};
                    end
                end
            end
            TSP_MODE1: begin
                for (int g = 0; g < 2; g++) begin
                    p = {z[2*g][0], 3'h0, z[2*g][1], 3'h0, z[2*g+1][0], 3'h0, z[2*g+1][1], 3'h0};
                    f[3*g][63 -: 16] = p[47:32];
                    f[3*g+1][63 -: 16] = p[31:16];
                    f[3*g+2][63 -: 16] = p[15:0];
                end
            end
            TSP_MODE2: begin
                for (int ch = 0; ch < TSP_CH; ch++) begin
                    f[ch][63 -: 8] = z[ch][0][8:1];
                end
            end
            default: begin
                for (int ch = 0; ch < TSP_CH; ch++) begin
                    for (int k = 0; k < 4; k++) begin
                        f[ch][63-10*k -: 10] = {z[ch][k], 1'b0};
                    end
                end
            end
        endcase
        // Bits beyond the fields were never written and stay zero.
        return f;
    endfunction

    // Collect samples, then shift the frame out a byte at a time. Sending
    // and collecting do not overlap, which the FIFO covers in bursts only.
    always_comb begin
        d = q;
        d.start = 1'b0;
        case (q.st)
            TSP_COLLECT: begin
                d.valid = 1'b0;
                d.lane_oct = '0;
                if (out_if.valid) begin
                    for (int ch = 0; ch < TSP_CH; ch++) begin
                        d.smp[ch][q.cnt] = out_if.data[9*ch +: 9];
                    end
                    if (q.cnt == TSP_NSMP[q.mode] - 4'h1) begin
                        d.cnt = '0;
                        d.frm = tsp_build(q.mode, q.cfg, d.smp);
                        for (int l = 0; l < TSP_LANES; l++) begin
                            d.lane_oct[8*l +: 8] = d.frm[l][63:56];
                            d.frm[l] = {d.frm[l][55:0], 8'h00};
                        end
                        d.oct = 4'h1;
                        d.valid = 1'b1;
                        d.start = 1'b1;
                        d.st = TSP_SEND;
                    end else begin
                        d.cnt = q.cnt + 4'h1;
                    end
                end
            end
            default: begin
                if (q.oct == TSP_NOCT[q.mode]) begin
                    d.valid = 1'b0;
                    d.lane_oct = '0;
                    d.st = TSP_COLLECT;
                end else begin
                    for (int l = 0; l < TSP_LANES; l++) begin
                        d.lane_oct[8*l +: 8] = q.frm[l][63:56];
                        d.frm[l] = {q.frm[l][55:0], 8'h00};
                    end
                    d.oct = q.oct + 4'h1;
                end
            end
        endcase
        // Mode and channel count are taken only while reset is held.
        if (!rst_n_i) begin
            d = '0;
            d.st = TSP_COLLECT;
            d.mode = tsp_mode_t'(link_mode_select_i);
            d.cfg = (chan_cfg_i == 2'h3) ? TSP_CFG_RST : tsp_cfg_t'(chan_cfg_i);
            d.en = TSP_LANE_EN[link_mode_select_i][(chan_cfg_i == 2'h3) ? 2'h2 : chan_cfg_i];
        end
    end

    // State register.
    always_ff @(posedge ref_clk_i) begin
        q <= d;
    end

    assign lane_octet_o = q.lane_oct;
    assign octet_valid_o = q.valid;
    assign frame_start_o = q.start;
    assign lane_en_o = q.en;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    mode0_length_a: assert property (
        frame_start_o && q.mode == TSP_MODE0 |-> octet_valid_o [*8] ##1 !octet_valid_o)
        else $error("mode 0 frame not eight octets");

    mode0_tail_a: assert property (
        frame_start_o && q.mode == TSP_MODE0 |-> ##7 lane_octet_o[3:0] == 4'h0 && lane_octet_o[11:8] == 4'h0)
        else $error("mode 0 tail not zero");

    mode1_order_a: assert property (
        frame_start_o && q.mode == TSP_MODE1 |-> lane_octet_o[7:0] == q.smp[0][0][8:1]
        ##1 lane_octet_o[7:0] == {q.smp[0][0][0], 3'h0, q.smp[0][1][8:5]} ##1 !octet_valid_o)
        else $error("mode 1 lane zero layout wrong");

    mode1_single_a: assert property (
        frame_start_o && q.mode == TSP_MODE1 && q.cfg == TSP_SINGLE |-> ##1 lane_octet_o[15:8] == 8'h00)
        else $error("mode 1 single lane one octet one not zero");

    mode2_msb_a: assert property (
        frame_start_o && q.mode == TSP_MODE2 |-> lane_octet_o[7:0] == $past(out_if.data[8:1]) ##1 !octet_valid_o)
        else $error("mode 2 lane zero not upper sample bits");

    mode3_field_a: assert property (
        frame_start_o && q.mode == TSP_MODE3 |-> lane_octet_o[7:0] == q.smp[0][0][8:1]
        ##4 octet_valid_o && lane_octet_o[0] == 1'b0 ##1 !octet_valid_o)
        else $error("mode 3 frame layout wrong");

    unused_lane_a: assert property (
        octet_valid_o && q.cfg == TSP_SINGLE && q.mode != TSP_MODE0 && q.mode != TSP_MODE1
        |-> lane_octet_o[63:8] == '0)
        else $error("unused lane driven in single mode");

    lane_mask_a: assert property (
        q.mode == TSP_MODE0 && q.cfg == TSP_QUAD |-> lane_en_o == 8'hff)
        else $error("mode 0 quad lanes not all enabled");

    first_nibble_a: assert property (
        frame_start_o && q.mode == TSP_MODE0 |-> lane_octet_o[7:0] == q.smp[0][0][8:1]
        ##1 lane_octet_o[7:0] == {q.smp[0][0][0], 3'h0, q.smp[0][2][8:5]})
        else $error("mode 0 octet order wrong");

endmodule

// ---- rtl/tsp_pkg.sv ----
/*
 * Shared constants and types for the transport sample packer.
 * Assumes samples arrive four channels wide on the packer clock.
 */
package tsp_pkg;

    // Geometry of the packer.
    localparam int unsigned TSP_CH = 4;
    localparam int unsigned TSP_LANES = 8;
    localparam int unsigned TSP_SW = 9;
    localparam int unsigned TSP_MAXS = 10;
    localparam int unsigned TSP_FRM_W = 64;
    localparam int unsigned TSP_FIFO_W = 36;
    localparam int unsigned TSP_FIFO_DEPTH = 16;

    // Link modes handled here.
    typedef enum logic [1:0] {
        TSP_MODE0 = 2'h0,
        TSP_MODE1 = 2'h1,
        TSP_MODE2 = 2'h2,
        TSP_MODE3 = 2'h3
    } tsp_mode_t;

    // Channel count of the device.
    typedef enum logic [1:0] {
        TSP_SINGLE = 2'h0,
        TSP_DUAL = 2'h1,
        TSP_QUAD = 2'h2
    } tsp_cfg_t;

    // Packer states, Gray along collect and send.
    typedef enum logic [1:0] {
        TSP_COLLECT = 2'h0,
        TSP_SEND = 2'h1
    } tsp_state_t;

    // Samples per channel gathered for one frame, per mode 3..0.
    localparam logic [3:0][3:0] TSP_NSMP = {4'h4, 4'h1, 4'h2, 4'ha};
    // Octets per lane frame, per mode 3..0.
    localparam logic [3:0][3:0] TSP_NOCT = {4'h5, 4'h1, 4'h2, 4'h8};
    // Lane enables per mode 3..0, each as quad, dual, single.
    localparam logic [3:0][2:0][7:0] TSP_LANE_EN = {
        8'h0f, 8'h03, 8'h01,
        8'h0f, 8'h03, 8'h01,
        8'h3f, 8'h07, 8'h03,
        8'hff, 8'h0f, 8'h03
    };

    // Reset values.
    localparam tsp_mode_t TSP_MODE_RST = TSP_MODE0;
    localparam tsp_cfg_t TSP_CFG_RST = TSP_QUAD;

endpackage

// ---- rtl/tsp_stream_if.sv ----
/*
 * Valid/ready word stream between the packer's own modules.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface tsp_stream_if #(
    parameter int unsigned W = 36
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/tsp_fifo.sv ----
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module tsp_fifo #(
    parameter int unsigned W = 36,
    parameter int unsigned DEPTH = 16
) (
    input wire logic ref_clk_i,      // Packer clock.
    input wire logic rst_n_i,        // Synchronous reset, active low.
    tsp_stream_if.snk in_if,         // Filling side.
    tsp_stream_if.src out_if         // Draining side.
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic not_full;
    } tsp_fifo_st_t;

    tsp_fifo_st_t q;
    tsp_fifo_st_t d;
    logic push;
    logic pop;

    // Ready is a flop of its own, so the upstream ready comes straight from a register.
    assign in_if.ready = q.not_full;
    assign out_if.valid = (q.cnt != '0);
    assign out_if.data = q.mem[q.rp];

    // Pointer and count update; a push and a pop together leave the count alone.
    always_comb begin
        d = q;
        push = in_if.valid && q.not_full;
        pop = out_if.valid && out_if.ready;
        if (push) begin
            d.mem[q.wp] = in_if.data;
            d.wp = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
        d.not_full = (d.cnt != (AW+1)'(DEPTH));
        if (!rst_n_i) begin
            d = '0;
            d.not_full = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge ref_clk_i) begin
        q <= d;
    end

    // The count never passes the depth.
    fifo_bound_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

// ---- tb/tsp_link_rx.sv ----
/*
 * Behavioural link receiver that gathers the packer's lane octets into frames.
 * Assumes one octet per lane per cycle and at least one idle cycle between frames.
 */
`timescale 1ns/1ps
module tsp_link_rx (
    input wire logic ref_clk_i,          // Packer clock.
    input wire logic rst_n_i,            // Synchronous reset, active low.
    input wire logic [63:0] lane_octet_i, // Octet per lane, lane_zero lowest.
    input wire logic octet_valid_i,      // Lane octets valid.
    input wire logic frame_start_i,      // Octet 0 of a frame.
    output logic [7:0][63:0] frame_o,    // Last whole frame per lane, octet 0 leftmost.
    output logic [7:0] frame_cnt_o       // Whole frames received.
);
    logic [7:0][63:0] acc_q;
    logic was_valid_q;

    // All eight lanes are wired in, so stray traffic on a powered-down lane is seen, not hidden.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            acc_q <= '0;
            frame_o <= '0;
            frame_cnt_o <= 8'h0;
            was_valid_q <= 1'b0;
        end else begin
            was_valid_q <= octet_valid_i;
            for (int l = 0; l < 8; l++) begin
                if (octet_valid_i && frame_start_i) begin
                    acc_q[l] <= 64'(lane_octet_i[8*l +: 8]);
                end else if (octet_valid_i) begin
                    acc_q[l] <= {acc_q[l][55:0], lane_octet_i[8*l +: 8]};
                end
            end
            if (was_valid_q && !octet_valid_i) begin
                frame_o <= acc_q;
                frame_cnt_o <= frame_cnt_o + 8'h1;
            end
        end
    end
endmodule

// ---- tb/tsp_packer_test.sv ----
/*
 * Self-checking bench for the transport packer, one task per scenario.
 * Assumes the packer drives frames that the receiver model can gather.
 */
`timescale 1ns/1ps
module tsp_packer_test;
    logic ref_clk_i;
    logic rst_n_i;
    logic [1:0] mode_sel;
    logic [1:0] chan_cfg;
    logic [35:0] sample_data;
    logic sample_valid;
    logic sample_ready;
    logic [63:0] lane_octet;
    logic octet_valid;
    logic frame_start;
    logic [7:0] lane_en;
    logic [7:0][63:0] rx_frame;
    logic [7:0] rx_cnt;
    int errors;
    int samples_checked;
    int stalls;

    tsp_packer u_tsp_packer (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_mode_select_i(mode_sel),
        .chan_cfg_i(chan_cfg), .sample_data_i(sample_data), .sample_valid_i(sample_valid),
        .sample_ready_o(sample_ready), .lane_octet_o(lane_octet), .octet_valid_o(octet_valid),
        .frame_start_o(frame_start), .lane_en_o(lane_en));
    tsp_link_rx u_tsp_link_rx (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .lane_octet_i(lane_octet),
        .octet_valid_i(octet_valid), .frame_start_i(frame_start), .frame_o(rx_frame), .frame_cnt_o(rx_cnt));

    // Free-running 100 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic complete_run();
        $display("Comparisons %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_lane(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: lane frame %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_en(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: lane mask %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_stall(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: input stall seen %b, expected %b", $time, got, exp);
        end
    endtask

    // Mode and channel count are only taken while reset is held, so every scenario restarts.
    task automatic restart(input logic [1:0] m, input logic [1:0] c);
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        mode_sel = m;
        chan_cfg = c;
        repeat (16) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
    endtask

    // Distinct sample per channel and index, spread over all nine bits.
    function automatic logic [8:0] smp(input int ch, input int n);
        return 9'(ch * 83 + n * 29 + 301);
    endfunction

    // Offers words back to back. Ready is looked at on the falling edge, where it has settled;
    // a word that stands with ready high is taken at the next rising edge.
    task automatic send(input int n);
        int t;
        for (int k = 0; k < n; k++) begin
            sample_data = {smp(3, k), smp(2, k), smp(1, k), smp(0, k)};
            sample_valid = 1'b1;
            t = 0;
            while (sample_ready !== 1'b1 && t < 200) begin
                @(negedge ref_clk_i);
                t++;
            end
            stalls += t;
            if (sample_ready !== 1'b1) begin
                errors++;
                complete_run();
            end
            @(negedge ref_clk_i);
        end
        sample_valid = 1'b0;
    endtask

    task automatic wait_frame(input logic [7:0] n);
        int t;
        t = 0;
        while (rx_cnt !== n && t < 300) begin
            @(negedge ref_clk_i);
            t++;
        end
        if (rx_cnt !== n) begin
            errors++;
            complete_run();
        end
    endtask

    task automatic lane_mask_table();
        logic [7:0] e;
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 4; c++) begin
                restart(2'(m), 2'(c));
                e = (c == 0) ? 8'h01 : (c == 1) ? 8'h03 : 8'h0f;
                if (m == 0) begin
                    e = (c == 0) ? 8'h03 : (c == 1) ? 8'h0f : 8'hff;
                end else if (m == 1) begin
                    e = (c == 0) ? 8'h03 : (c == 1) ? 8'h07 : 8'h3f;
                end
                chk_en(lane_en, e);
            end
        end
    endtask

    // Four frames back to back outrun the drain, so the FIFO fills and ready must drop;
    // the last frame proves that no word was lost or reordered under the stall.
    task automatic mode0_quad();
        logic [63:0] e;
        restart(2'h0, 2'h2);
        stalls = 0;
        send(40);
        wait_frame(8'h4);
        chk_stall(stalls > 0, 1'b1);
        for (int l = 0; l < 8; l++) begin
            e = '0;
            for (int k = 0; k < 5; k++) begin
                e[63-12*k -: 12] = {smp(l / 2, 30 + 2 * k + l % 2), 3'h0};
            end
            chk_lane(rx_frame[l], e);
        end
    endtask

    // Fields of absent channels are zero, which covers the zero octet of a single device.
    task automatic mode1_pack(input logic [1:0] c, input int nch);
        logic [127:0] st;
        restart(2'h1, c);
        send(2);
        wait_frame(8'h1);
        st = '0;
        for (int f = 0; f < 8; f++) begin
            if (f / 2 < nch) begin
                st[127-12*f -: 12] = {smp(f / 2, f % 2), 3'h0};
            end
        end
        for (int l = 0; l < 8; l++) begin
            chk_lane(rx_frame[l], (l < 6) ? 64'(st[127-16*l -: 16]) : 64'h0);
        end
    endtask

    task automatic mode2_dual();
        logic [8:0] s;
        restart(2'h2, 2'h1);
        send(1);
        wait_frame(8'h1);
        for (int l = 0; l < 8; l++) begin
            s = smp(l, 0);
            chk_lane(rx_frame[l], (l < 2) ? 64'(s[8:1]) : 64'h0);
        end
    endtask

    task automatic mode3_quad();
        logic [63:0] e;
        restart(2'h3, 2'h2);
        send(4);
        wait_frame(8'h1);
        for (int l = 0; l < 8; l++) begin
            e = '0;
            for (int k = 0; k < 4; k++) begin
                e[39-10*k -: 10] = (l < 4) ? {smp(l, k), 1'b0} : 10'h0;
            end
            chk_lane(rx_frame[l], e);
        end
    endtask

    // Main sequence.
    initial begin
        errors = 0;
        samples_checked = 0;
        stalls = 0;
        rst_n_i = 1'b0;
        mode_sel = 2'h0;
        chan_cfg = 2'h2;
        sample_data = 36'h0;
        sample_valid = 1'b0;
        lane_mask_table();
        mode0_quad();
        mode1_pack(2'h2, 4);
        mode1_pack(2'h0, 1);
        mode2_dual();
        mode3_quad();
        complete_run();
    end
endmodule
